// file: src/rtop_pkg.sv
// package for the output pin and power-on defaults block
// assumes a single 125 MHz clock and plain control ports
package rtop_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ = 125000000;
	localparam int TEST_TONE_HZ = 512;
	// half period of the 512 Hz test tone in clock cycles
	localparam int TONE_HALF_CYC = CLK_HZ / (2 * TEST_TONE_HZ);
	localparam int TONE_CNT_W = 18;
	localparam logic [TONE_CNT_W-1:0] TONE_HALF_LAST = TONE_CNT_W'(TONE_HALF_CYC - 1);
	// ----------------------------------------
	// power-up defaults
	// ----------------------------------------
	localparam logic INIT_HALT = 1'b1;
	localparam logic INIT_LEVEL = 1'b0;
	localparam logic INIT_TEST = 1'b0;
	localparam logic INIT_FAIL = 1'b1;
	// power-up kind
	typedef enum logic [1:0] {
		RTOP_PWR_RUN = 2'b00,
		RTOP_PWR_FIRST = 2'b01,
		RTOP_PWR_BACKED = 2'b10
	} rtop_pwr_e;
	// control bits held by the block
	typedef struct packed {
		logic osc_halt_bit;
		logic out_level;
		logic freq_test_enable;
		logic osc_failure_flag;
	} rtop_ctrl_s;
	// software write request: one strobe per bit plus data
	typedef struct packed {
		logic wr_halt;
		logic wr_level;
		logic wr_test;
		logic wr_fail;
		rtop_ctrl_s data;
	} rtop_wr_s;
endpackage

// file: src/rtop_tone.sv
// 512 Hz test tone generator
// assumes a free running 125 MHz clock; runs only while enabled
module rtop_tone
	import rtop_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// control
	input wire logic i_en,
	// tone
	output logic o_tone
);
	logic [TONE_CNT_W-1:0] cnt;
	// ----------------------------------------
	// half period counter
	// ----------------------------------------
	// held at zero while disabled so each test burst starts phase aligned
	always_ff @(posedge i_clk) begin
		if (!i_rst_b || !i_en) begin
			cnt <= '0;
			o_tone <= 1'b0;
		end else if (cnt == TONE_HALF_LAST) begin
			cnt <= '0;
			o_tone <= ~o_tone;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end
endmodule

// file: src/rtop_core.sv
// output pin control and power-on defaults of the clock's control bits
// assumes one 125 MHz clock; bus engine outside supplies write strobes
module rtop_core
	import rtop_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// power-up events, one-cycle pulses
	input wire logic i_first_power_up,
	input wire logic i_backed_power_up,
	// software writes from the bus engine
	input wire rtop_wr_s i_wr,
	// oscillator fault detector, level
	input wire logic i_osc_fault,
	// control bit state
	output rtop_ctrl_s o_ctrl,
	// combined pin, open drain
	output logic o_test_or_level_pin_out,
	output logic o_test_or_level_pin_oe,
	input wire logic i_test_or_level_pin_in
);
	rtop_ctrl_s ctrl;
	rtop_pwr_e pwr_kind;
	logic tone;
	logic tone_en;
	logic pin_low;
	logic [TONE_CNT_W-1:0] tone_age;

	// ----------------------------------------
	// power-up classification
	// ----------------------------------------
	// first power-up outranks a backed one if both appear together
	always_comb begin
		if (i_first_power_up) begin
			pwr_kind = RTOP_PWR_FIRST;
		end else if (i_backed_power_up) begin
			pwr_kind = RTOP_PWR_BACKED;
		end else begin
			pwr_kind = RTOP_PWR_RUN;
		end
	end

	// ----------------------------------------
	// control bits
	// ----------------------------------------
	// synchronous reset acts as a first power-up; other bits are not held here
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			ctrl <= '{INIT_HALT, INIT_LEVEL, INIT_TEST, INIT_FAIL};
		end else begin
			case (pwr_kind)
				RTOP_PWR_FIRST: begin
					ctrl <= '{INIT_HALT, INIT_LEVEL, INIT_TEST, INIT_FAIL};
				end
				RTOP_PWR_BACKED: begin
					ctrl.freq_test_enable <= INIT_TEST;
				end
				RTOP_PWR_RUN: begin
					if (i_wr.wr_halt) begin
						ctrl.osc_halt_bit <= i_wr.data.osc_halt_bit;
					end
					if (i_wr.wr_level) begin
						ctrl.out_level <= i_wr.data.out_level;
					end
					if (i_wr.wr_test) begin
						ctrl.freq_test_enable <= i_wr.data.freq_test_enable;
					end
					// a fault in the same cycle as a clear wins, flag stays set
					if (i_osc_fault || ctrl.osc_halt_bit) begin
						ctrl.osc_failure_flag <= 1'b1;
					end else if (i_wr.wr_fail && !i_wr.data.osc_failure_flag) begin
						ctrl.osc_failure_flag <= 1'b0;
					end
				end
				default: begin
					ctrl <= ctrl;
				end
			endcase
		end
	end

	assign o_ctrl = ctrl;

	// ----------------------------------------
	// test tone
	// ----------------------------------------
	assign tone_en = ctrl.freq_test_enable && !ctrl.osc_halt_bit;

	rtop_tone u_tone (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_en(tone_en),
		.o_tone(tone)
	);

	// ----------------------------------------
	// pin driver
	// ----------------------------------------
	// with test set but halted, the tone stops and the pin is released
	always_comb begin
		if (!ctrl.freq_test_enable) begin
			pin_low = !ctrl.out_level;
		end else begin
			pin_low = tone_en && !tone;
		end
	end

	// only ever sink; a high level comes from the external pull-up
	assign o_test_or_level_pin_out = 1'b0;
	assign o_test_or_level_pin_oe = pin_low;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_level_follow;
		@(posedge i_clk) disable iff (!i_rst_b)
		!ctrl.freq_test_enable |-> (o_test_or_level_pin_oe == !ctrl.out_level);
	endproperty
	a_level_follow: assert property (p_level_follow) else $error("pin not following level");

	property p_both_zero_low;
		@(posedge i_clk) disable iff (!i_rst_b)
		(!ctrl.out_level && !ctrl.freq_test_enable) |-> o_test_or_level_pin_oe;
	endproperty
	a_both_zero_low: assert property (p_both_zero_low) else $error("pin not pulled low");

	property p_never_high;
		@(posedge i_clk) disable iff (!i_rst_b)
		o_test_or_level_pin_out == 1'b0;
	endproperty
	a_never_high: assert property (p_never_high) else $error("pin driven high");

	property p_first_defaults;
		@(posedge i_clk) disable iff (!i_rst_b)
		i_first_power_up |=> (ctrl.osc_halt_bit && !ctrl.out_level
			&& !ctrl.freq_test_enable && ctrl.osc_failure_flag);
	endproperty
	a_first_defaults: assert property (p_first_defaults) else $error("bad first defaults");

	property p_backed_keep;
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_backed_power_up && !i_first_power_up) |=> (!ctrl.freq_test_enable
			&& ctrl.osc_halt_bit == $past(ctrl.osc_halt_bit)
			&& ctrl.out_level == $past(ctrl.out_level)
			&& ctrl.osc_failure_flag == $past(ctrl.osc_failure_flag));
	endproperty
	a_backed_keep: assert property (p_backed_keep) else $error("bad backed power-up");

	property p_tone_toggles;
		@(posedge i_clk) disable iff (!i_rst_b)
		(tone_en && $rose(tone)) |-> ##1 (tone || !tone_en);
	endproperty
	a_tone_toggles: assert property (p_tone_toggles) else $error("tone glitch");

	property p_tone_release;
		@(posedge i_clk) disable iff (!i_rst_b)
		(ctrl.freq_test_enable && ctrl.osc_halt_bit) |-> !o_test_or_level_pin_oe;
	endproperty
	a_tone_release: assert property (p_tone_release) else $error("halted tone drives");

	property p_fail_sticky;
		@(posedge i_clk) disable iff (!i_rst_b)
		(ctrl.osc_failure_flag && !i_first_power_up
			&& !(i_wr.wr_fail && !i_wr.data.osc_failure_flag)) |=> ctrl.osc_failure_flag;
	endproperty
	a_fail_sticky: assert property (p_fail_sticky) else $error("fail flag self-cleared");

	property p_fail_set;
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_osc_fault && !i_backed_power_up) |=> ctrl.osc_failure_flag;
	endproperty
	a_fail_set: assert property (p_fail_set) else $error("fault did not set fail flag");

	property p_level_write;
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_wr.wr_level && !i_first_power_up && !i_backed_power_up)
			|=> (ctrl.out_level == $past(i_wr.data.out_level));
	endproperty
	a_level_write: assert property (p_level_write) else $error("level write lost");

	property p_test_write;
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_wr.wr_test && !i_first_power_up && !i_backed_power_up)
			|=> (ctrl.freq_test_enable == $past(i_wr.data.freq_test_enable));
	endproperty
	a_test_write: assert property (p_test_write) else $error("test write lost");

	property p_pin_reads_low;
		@(posedge i_clk) disable iff (!i_rst_b)
		o_test_or_level_pin_oe |-> !i_test_or_level_pin_in;
	endproperty
	a_pin_reads_low: assert property (p_pin_reads_low) else $error("sunk pin reads high");

	// ----------------------------------------
	// tone period checks
	// ----------------------------------------
	// cycles the tone has stood since it was enabled or last flipped;
	// a full half period is too long for the bench, so it is checked here
	always_ff @(posedge i_clk) begin
		if (!i_rst_b || !tone_en) begin
			tone_age <= '0;
		end else if (tone_age == TONE_HALF_LAST) begin
			tone_age <= '0;
		end else begin
			tone_age <= tone_age + 1'b1;
		end
	end

	property p_tone_hold;
		@(posedge i_clk) disable iff (!i_rst_b)
		(tone_en && tone_age != TONE_HALF_LAST) |=> (!tone_en || $stable(tone));
	endproperty
	a_tone_hold: assert property (p_tone_hold) else $error("tone flipped early");

	property p_tone_flip;
		@(posedge i_clk) disable iff (!i_rst_b)
		(tone_en && tone_age == TONE_HALF_LAST) |=> $changed(tone);
	endproperty
	a_tone_flip: assert property (p_tone_flip) else $error("tone missed its flip");
endmodule

// file: test/rtop_pullup.sv
// far side of the combined pin: the board's pull-up resistor
// assumes the core only ever sinks the pin and never drives it high
module rtop_pullup
	import rtop_pkg::*;
(
	// core side
	input wire logic i_out,
	input wire logic i_oe,
	// resolved wire level
	output logic o_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	// a released pin floats up through the resistor, never stays at the last value
	assign o_pin = i_oe ? i_out : 1'b1;
endmodule

// file: test/tb_top.sv
// self-checking bench for the pin control and power-up defaults core
// assumes no bus engine: write strobes and power-up pulses come from here
module tb_top
	import rtop_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// stimulus table and signals
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] wr;
		logic [3:0] ctrl;
		logic pin;
	} rtop_row_s;
	// strobes halt,level,test,fail then data in the same order
	rtop_row_s rows [6] = '{'{8'h44, 4'hd, 1'b1}, '{8'h80, 4'h5, 1'b1}, '{8'h10, 4'h4, 1'b1},
		'{8'h40, 4'h0, 1'b0}, '{8'h22, 4'h2, 1'b0}, '{8'h44, 4'h6, 1'b0}};
	// 10 us of idle bus after power returns, at 8 ns per cycle
	localparam int BUS_IDLE_CYC = 1250;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic first_pu = 1'b0;
	logic backed_pu = 1'b0;
	logic osc_fault = 1'b0;
	rtop_wr_s wr = '0;
	rtop_ctrl_s ctrl;
	logic pin_out;
	logic pin_oe;
	logic pin;
	int error_cnt = 0;
	int n_checks = 0;
	always #4 clk = ~clk;
	rtop_core u_rtop_core (.i_clk(clk), .i_rst_b(rst_b), .i_first_power_up(first_pu),
		.i_backed_power_up(backed_pu), .i_wr(wr), .i_osc_fault(osc_fault), .o_ctrl(ctrl),
		.o_test_or_level_pin_out(pin_out), .o_test_or_level_pin_oe(pin_oe),
		.i_test_or_level_pin_in(pin));
	rtop_pullup u_rtop_pullup (.i_out(pin_out), .i_oe(pin_oe), .o_pin(pin));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// one-cycle write strobe, then a second edge so the registered answer has landed
	task automatic apply(input logic [7:0] w);
		wr = rtop_wr_s'(w);
		@(negedge clk);
		wr = '0;
		@(negedge clk);
	endtask
	task automatic chk_ctrl(input string what, input logic [3:0] exp);
		n_checks++;
		if (ctrl !== rtop_ctrl_s'(exp)) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, ctrl);
		end
	endtask
	task automatic chk_pin(input string what, input logic exp);
		n_checks++;
		if (pin !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, pin);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (3) @(negedge clk);
		chk_ctrl("reset ctrl", 4'h9);
		chk_pin("reset pin", 1'b0);
		rst_b = 1'b1;
		$display("reset test done");
		for (int i = 0; i < 6; i++) begin
			apply(rows[i].wr);
			chk_ctrl("row ctrl", rows[i].ctrl);
			chk_pin("row pin", rows[i].pin);
			$display("row %0d done", i);
		end
		// tone starts in its low half and its half period is far longer than this
		repeat (100) @(negedge clk);
		chk_pin("tone start", 1'b0);
		// a write landing in the power-up cycle must be ignored
		backed_pu = 1'b1;
		wr = rtop_wr_s'(8'h40);
		@(negedge clk);
		backed_pu = 1'b0;
		wr = '0;
		@(negedge clk);
		chk_ctrl("backed ctrl", 4'h4);
		chk_pin("backed pin", 1'b1);
		$display("backed power-up test done");
		osc_fault = 1'b1;
		repeat (2) @(negedge clk);
		apply(8'h10);
		chk_ctrl("fail held", 4'h5);
		osc_fault = 1'b0;
		apply(8'h10);
		chk_ctrl("fail cleared", 4'h4);
		$display("fail flag test done");
		first_pu = 1'b1;
		@(negedge clk);
		first_pu = 1'b0;
		@(negedge clk);
		chk_ctrl("first ctrl", 4'h9);
		chk_pin("first pin", 1'b0);
		$display("first power-up test done");
		// the master keeps the bus idle after power returns, then writes
		repeat (BUS_IDLE_CYC) @(negedge clk);
		apply(8'h44);
		chk_ctrl("idle then write", 4'hd);
		chk_pin("idle then pin", 1'b1);
		$display("bus idle test done");
		// reset in mid-run acts as a first power-up; a write follows at once
		rst_b = 1'b0;
		@(negedge clk);
		chk_ctrl("mid reset ctrl", 4'h9);
		chk_pin("mid reset pin", 1'b0);
		rst_b = 1'b1;
		apply(8'h22);
		chk_ctrl("halted test ctrl", 4'hb);
		chk_pin("halted test pin", 1'b1);
		$display("mid-run reset test done");
		complete_run;
	end
	// the tests need about 1400 cycles; this limit leaves ample margin
	initial begin
		repeat (4000) @(posedge clk);
		error_cnt++;
		$display("watchdog expired");
		complete_run;
	end
endmodule
